// ---- rtl/ifeu_holdoff.sv ----
`timescale 1ns/100ps
`default_nettype none
module ifeu_holdoff
    import ifeu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstnSync,
    input wire logic clkEn,
    input wire logic [7:0] interval,
    input wire logic restart,
    input wire logic lineFall,
    output logic active
);
    logic [11:0] tick;
    logic [7:0] units;

    // interval starts when the line drops; zero interval cancels it
    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            active <= 1'b0;
            units <= HOLD_OFF;
            tick <= 12'h000;
        end else if (clkEn) begin
            if (interval == HOLD_OFF) begin
                active <= 1'b0;
                units <= HOLD_OFF;
                tick <= 12'h000;
            end else if (restart || lineFall) begin
                active <= 1'b1;
                units <= interval;
                tick <= UNIT_CYCLES - 12'h001;
            end else if (active) begin
                if (tick != 12'h000) begin
                    tick <= tick - 12'h001;
                end else if (units == 8'h01) begin
                    active <= 1'b0;
                end else begin
                    units <= units - 8'h01;
                    tick <= UNIT_CYCLES - 12'h001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ifeu_pkg.sv ----
package ifeu_pkg;
    localparam logic [11:0] ADDR_CTL = 12'h000;
    localparam logic [11:0] ADDR_FLAG = 12'h004;
    localparam logic [11:0] ADDR_EN = 12'h008;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam int BIT_SOFT = 31;
    localparam int BIT_READY = 30;
    localparam int BIT_PHYB = 27;
    localparam int BIT_PHYA = 26;
    localparam int BIT_TIMER = 19;
    localparam int BIT_POWER = 17;
    localparam int BIT_BRIDGE = 14;
    localparam int BIT_CORE = 0;
    // sticky flags, cleared by writing one
    localparam logic [31:0] MASK_STICKY = 32'hC00A_0000;
    // flags that mirror a source level
    localparam logic [31:0] MASK_MIRROR = 32'h0C00_4001;
    localparam logic [31:0] MASK_EN = 32'hCC0A_4001;
    localparam logic [31:0] MASK_POWER = 32'h0002_0000;
    localparam int CTL_MODE = 0;
    localparam int CTL_POL = 4;
    localparam int CTL_PINEN = 8;
    localparam int CTL_STAT = 12;
    localparam int CTL_HSTAT = 13;
    localparam int CTL_HCLR = 14;
    localparam int CTL_HOLD_LO = 24;
    localparam int CTL_HOLD_HI = 31;
    localparam logic [15:0] TIMER_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
    localparam int CLK_MHZ = 250;
    localparam int UNIT_US = 10;
    localparam logic [11:0] UNIT_CYCLES = 12'(UNIT_US * CLK_MHZ);
    localparam logic [7:0] HOLD_OFF = 8'h00;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;
endpackage

// ---- rtl/ifeu_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ifeu_top
    import ifeu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic firstPhyEvent,
    input wire logic secondPhyEvent,
    input wire logic bridgeEvent,
    input wire logic fieldbusCoreEvent,
    input wire logic [15:0] timerCount,
    input wire logic powerEvent,
    output logic irqOut,
    output logic irqOutEn
);
    ////////////////////////////////////////////////////////////////////////
    logic rstnMeta, rstnSync;
    logic [31:0] flags, enables;
    logic [7:0] holdoffInterval;
    logic pinOutputEnable, pinActiveLevel, pinDriveMode;
    logic holdoffRestart, holdoffActive;
    logic readyPending;
    logic [15:0] timerPrev;
    logic lineStatus, powerLine, otherLine, otherPrev, pinAssert;
    logic wrAcc, knownAddr;
    logic [31:0] wmask, next_flags, ctlRead;

    function automatic logic [31:0] laneMask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        return a == ADDR_CTL || a == ADDR_FLAG || a == ADDR_EN;
    endfunction

    // reset released through two stages
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstnMeta <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstnMeta <= 1'b1;
            rstnSync <= rstnMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, unmapped address answers with pslverr
    assign pready = 1'b1;
    assign knownAddr = isMapped(paddr);
    assign wrAcc = clkEn && psel && penable && pwrite && knownAddr;
    assign wmask = laneMask(pstrb);
    assign pslverr = psel && penable && !knownAddr;

    always_comb begin
        ctlRead = RST_ZERO;
        ctlRead[CTL_HOLD_HI:CTL_HOLD_LO] = holdoffInterval;
        ctlRead[CTL_HSTAT] = holdoffActive;
        ctlRead[CTL_STAT] = lineStatus;
        ctlRead[CTL_PINEN] = pinOutputEnable;
        ctlRead[CTL_POL] = pinActiveLevel;
        ctlRead[CTL_MODE] = pinDriveMode;
    end

    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            prdata <= RST_ZERO;
        end else if (clkEn && psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_CTL: prdata <= ctlRead;
                ADDR_FLAG: prdata <= flags;
                ADDR_EN: prdata <= enables;
                default: prdata <= ERR_DATA;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            holdoffInterval <= HOLD_OFF;
            pinOutputEnable <= 1'b0;
            pinActiveLevel <= 1'b0;
            pinDriveMode <= 1'b0;
            holdoffRestart <= 1'b0;
        end else if (clkEn) begin
            holdoffRestart <= 1'b0;
            if (wrAcc && paddr == ADDR_CTL) begin
                if (pstrb[3]) begin
                    holdoffInterval <= pwdata[CTL_HOLD_HI:CTL_HOLD_LO];
                end
                if (pstrb[1]) begin
                    pinOutputEnable <= pwdata[CTL_PINEN];
                    holdoffRestart <= pwdata[CTL_HCLR];
                end
                if (pstrb[0]) begin
                    pinActiveLevel <= pwdata[CTL_POL];
                    pinDriveMode <= pwdata[CTL_MODE];
                end
            end
        end
    end

    // enable register; reserved bits stay zero
    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            enables <= RST_ZERO;
        end else if (clkEn && wrAcc && paddr == ADDR_EN) begin
            enables <= (enables & ~wmask) | (pwdata & wmask & MASK_EN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: set wins over a write-one clear
    always_comb begin
        next_flags = flags;
        if (wrAcc && paddr == ADDR_FLAG) begin
            next_flags = flags & ~(pwdata & wmask & MASK_STICKY);
        end
        next_flags[BIT_SOFT] = next_flags[BIT_SOFT] | enables[BIT_SOFT];
        next_flags[BIT_READY] = next_flags[BIT_READY] | readyPending;
        if (timerPrev == TIMER_ZERO && timerCount == TIMER_ALL_ONES) begin
            next_flags[BIT_TIMER] = 1'b1;
        end
        next_flags[BIT_POWER] = next_flags[BIT_POWER] | powerEvent;
        next_flags[BIT_PHYB] = secondPhyEvent;
        next_flags[BIT_PHYA] = firstPhyEvent;
        next_flags[BIT_BRIDGE] = bridgeEvent;
        next_flags[BIT_CORE] = fieldbusCoreEvent;
    end

    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            flags <= RST_ZERO;
            readyPending <= 1'b1;
            timerPrev <= TIMER_ZERO;
        end else if (clkEn) begin
            flags <= next_flags;
            readyPending <= 1'b0;
            timerPrev <= timerCount;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal line and pin
    assign lineStatus = |(flags & enables);
    assign powerLine = |(flags & enables & MASK_POWER);
    assign otherLine = |(flags & enables & ~MASK_POWER);

    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            otherPrev <= 1'b0;
        end else if (clkEn) begin
            otherPrev <= otherLine;
        end
    end

    ifeu_holdoff uHoldoff (
        .clk_sys(clk_sys),
        .rstnSync(rstnSync),
        .clkEn(clkEn),
        .interval(holdoffInterval),
        .restart(holdoffRestart),
        .lineFall(otherPrev && !otherLine),
        .active(holdoffActive)
    );

    // power event skips the interval
    assign pinAssert = pinOutputEnable &&
        (powerLine || (otherLine && !holdoffActive));

    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            irqOut <= 1'b1;
            irqOutEn <= 1'b0;
        end else if (clkEn) begin
            if (!pinDriveMode) begin
                irqOut <= 1'b0;
                irqOutEn <= pinAssert;
            end else begin
                irqOut <= pinAssert ~^ pinActiveLevel;
                irqOutEn <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_SOFT: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && enables[BIT_SOFT] |=> flags[BIT_SOFT])
        else $error("soft flag not raised");
    AST_READY: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        $rose(rstnSync) |-> ##[0:3] flags[BIT_READY])
        else $error("ready flag missing");
    AST_TIMER: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && timerPrev == TIMER_ZERO && timerCount == TIMER_ALL_ONES
        |=> flags[BIT_TIMER])
        else $error("timer wrap lost");
    AST_MIRROR: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn |=> flags[BIT_PHYA] == $past(firstPhyEvent))
        else $error("phy flag mismatch");
    AST_PHYB: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn |=> flags[BIT_PHYB] == $past(secondPhyEvent))
        else $error("second phy flag mismatch");
    AST_BRIDGE: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn |=> flags[BIT_BRIDGE] == $past(bridgeEvent))
        else $error("bridge flag mismatch");
    AST_CORE: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn |=> flags[BIT_CORE] == $past(fieldbusCoreEvent))
        else $error("core flag mismatch");
    AST_POWSET: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && powerEvent |=> flags[BIT_POWER])
        else $error("power flag not raised");
    AST_RESERVED: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        (flags & ~(MASK_STICKY | MASK_MIRROR)) == RST_ZERO
        && (enables & ~MASK_EN) == RST_ZERO)
        else $error("reserved bit set");
    AST_STATUS: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && psel && !penable && !pwrite && paddr == ADDR_CTL
        |=> prdata[CTL_STAT] == $past(|(flags & enables)))
        else $error("status wrong");
    AST_RDFLAG: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && psel && !penable && !pwrite && paddr == ADDR_FLAG
        |=> prdata == $past(flags))
        else $error("flag readback wrong");
    AST_RDEN: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && psel && !penable && !pwrite && paddr == ADDR_EN
        |=> prdata == $past(enables))
        else $error("enable readback wrong");
    AST_PINOFF: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && !pinOutputEnable && !pinDriveMode |=> !irqOutEn)
        else $error("pin driven while off");
    AST_POWER: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && pinOutputEnable && powerLine && pinDriveMode
        |=> irqOut == $past(pinActiveLevel))
        else $error("power irq held off");
    AST_HOLD: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && pinDriveMode && holdoffActive && !powerLine
        |=> irqOut == !$past(pinActiveLevel))
        else $error("irq leaked through holdoff");
    AST_OPENDRAIN: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && !pinDriveMode |=> !irqOut)
        else $error("open drain pin not low");
    AST_PUSHPULL: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && pinDriveMode |=> irqOutEn)
        else $error("push pull pin not driven");
    AST_STICKY: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && flags[BIT_TIMER] && !(wrAcc && paddr == ADDR_FLAG)
        |=> flags[BIT_TIMER])
        else $error("sticky flag lost");
    AST_CLEAR: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && wrAcc && paddr == ADDR_FLAG && pwdata[BIT_TIMER]
        && wmask[BIT_TIMER] && timerPrev != TIMER_ZERO |=> !flags[BIT_TIMER])
        else $error("write one did not clear");
    AST_WRZERO: assert property (@(posedge clk_sys)
        disable iff (!rstnSync)
        clkEn && flags[BIT_POWER] && !(wrAcc && paddr == ADDR_FLAG
        && pwdata[BIT_POWER] && wmask[BIT_POWER]) |=> flags[BIT_POWER])
        else $error("flag lost without write one");
    COV_PIN: cover property (@(posedge clk_sys) irqOutEn && !irqOut);
    COV_HOLD: cover property (@(posedge clk_sys) holdoffActive);
    COV_CLR: cover property (@(posedge clk_sys) wrAcc && paddr == ADDR_FLAG);
    COV_POWER: cover property (@(posedge clk_sys)
        powerLine && holdoffActive && irqOut);
    COV_FREEZE: cover property (@(posedge clk_sys) !clkEn && psel && penable);
endmodule
`default_nettype wire

// ---- verif/ifeu_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// host end of the interrupt pin; a board pull-up holds the line high
// whenever the device releases it, so open drain reads high when idle
module ifeu_host_model (
    input wire logic irqOut,
    input wire logic irqOutEn,
    output logic pinWire
);
    assign pinWire = irqOutEn ? irqOut : 1'b1;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb
    import ifeu_pkg::*;
;
    localparam int LIMIT = 5000;
    localparam int SRC_BIT [4] = '{BIT_PHYA, BIT_PHYB, BIT_BRIDGE, BIT_CORE};
    localparam logic [31:0] PP = 32'h0000_0111;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] srcs = 4'h0;
    logic [15:0] timerCount = 16'h0000;
    logic powerEvent = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, perr, irqOut, irqOutEn, pinWire;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    ifeu_top dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .firstPhyEvent(srcs[0]),
        .secondPhyEvent(srcs[1]), .bridgeEvent(srcs[2]),
        .fieldbusCoreEvent(srcs[3]), .timerCount(timerCount),
        .powerEvent(powerEvent), .irqOut(irqOut), .irqOutEn(irqOutEn));
    ifeu_host_model host (.irqOut(irqOut), .irqOutEn(irqOutEn),
        .pinWire(pinWire));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // the limit stands in for a hung handshake as well
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // the spare edge at the end keeps two transfers from touching psel
    // within one time step
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdata, e)
    endtask

    initial begin
        idle(12);
        rstn <= 1'b1;
        idle(3);
        rd(ADDR_FLAG, 32'h1 << BIT_READY);
        rd(ADDR_EN, RST_ZERO);
        `CHK(irqOutEn, 1'b0)
        wr(ADDR_FLAG, 32'h0000_0000);
        rd(ADDR_FLAG, 32'h1 << BIT_READY);
        wr(ADDR_FLAG, 32'h1 << BIT_READY);
        rd(ADDR_FLAG, RST_ZERO);
        for (int i = 0; i < 4; i++) begin
            srcs[i] <= 1'b1;
            idle(3);
            rd(ADDR_FLAG, 32'h1 << SRC_BIT[i]);
            wr(ADDR_FLAG, MASK_MIRROR);
            rd(ADDR_FLAG, 32'h1 << SRC_BIT[i]);
            srcs[i] <= 1'b0;
            idle(3);
            rd(ADDR_FLAG, RST_ZERO);
        end
        // a step into all ones from anything but zero is no wrap
        timerCount <= 16'hFFFE;
        idle(2);
        timerCount <= TIMER_ALL_ONES;
        idle(3);
        rd(ADDR_FLAG, RST_ZERO);
        timerCount <= TIMER_ZERO;
        idle(2);
        timerCount <= TIMER_ALL_ONES;
        idle(2);
        timerCount <= 16'h1234;
        idle(2);
        rd(ADDR_FLAG, 32'h1 << BIT_TIMER);
        wr(ADDR_FLAG, 32'h1 << BIT_TIMER);
        rd(ADDR_FLAG, RST_ZERO);
        powerEvent <= 1'b1;
        idle(1);
        powerEvent <= 1'b0;
        idle(3);
        rd(ADDR_FLAG, MASK_POWER);
        wr(ADDR_FLAG, MASK_POWER);
        rd(ADDR_FLAG, RST_ZERO);
        wr(ADDR_EN, MASK_EN);
        rd(ADDR_EN, MASK_EN);
        rd(ADDR_FLAG, 32'h1 << BIT_SOFT);
        rd(ADDR_CTL, 32'h1 << CTL_STAT);
        `CHK(irqOutEn, 1'b0)
        wr(ADDR_CTL, 32'h1 << CTL_PINEN);
        idle(3);
        `CHK(pinWire, 1'b0)
        `CHK(irqOut, 1'b0)
        wr(ADDR_CTL, PP);
        idle(3);
        `CHK({irqOut, irqOutEn}, 2'b11)
        wr(ADDR_CTL, PP & ~(32'h1 << CTL_POL));
        idle(3);
        `CHK(irqOut, 1'b0)
        wr(ADDR_EN, RST_ZERO);
        idle(3);
        `CHK(irqOut, 1'b1)
        rd(ADDR_CTL, 32'h0000_0101);
        wr(ADDR_FLAG, 32'h1 << BIT_SOFT);
        rd(ADDR_FLAG, RST_ZERO);
        // holdoff of one unit far outlasts the steps below
        wr(ADDR_CTL, PP | 32'h0100_0000);
        wr(ADDR_EN, MASK_POWER | 32'h1);
        srcs[3] <= 1'b1;
        idle(3);
        `CHK(irqOut, 1'b1)
        srcs[3] <= 1'b0;
        idle(3);
        srcs[3] <= 1'b1;
        idle(3);
        `CHK(irqOut, 1'b0)
        rd(ADDR_CTL, PP | 32'h0100_3000);
        powerEvent <= 1'b1;
        idle(1);
        powerEvent <= 1'b0;
        idle(3);
        `CHK(irqOut, 1'b1)
        wr(ADDR_FLAG, MASK_POWER);
        idle(3);
        `CHK(irqOut, 1'b0)
        wr(ADDR_CTL, PP);
        idle(3);
        `CHK(irqOut, 1'b1)
        wr(12'h00C, 32'hFFFF_FFFF);
        `CHK(perr, 1'b1)
        rd(ADDR_EN, MASK_POWER | 32'h1);
        // a frozen block neither samples sources nor takes writes
        clkEn <= 1'b0;
        powerEvent <= 1'b1;
        wr(ADDR_EN, RST_ZERO);
        clkEn <= 1'b1;
        powerEvent <= 1'b0;
        rd(ADDR_EN, MASK_POWER | 32'h1);
        rd(ADDR_FLAG, 32'h1 << BIT_CORE);
        // only the third byte lane lands
        pstrb <= 4'h4;
        wr(ADDR_EN, MASK_EN);
        pstrb <= 4'hF;
        rd(ADDR_EN, 32'h000A_0001);
        // restart opens a holdoff although the line never fell
        wr(ADDR_CTL, PP | 32'h0100_4000);
        rd(ADDR_CTL, PP | 32'h0100_3000);
        `CHK(irqOut, 1'b0)
        // second reset in mid-run: ready comes back, the rest clears
        srcs[3] <= 1'b0;
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(3);
        rd(ADDR_FLAG, 32'h1 << BIT_READY);
        rd(ADDR_CTL, RST_ZERO);
        rd(ADDR_EN, RST_ZERO);
        `CHK(irqOutEn, 1'b0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
